// file: src/srt_signaling_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Seven signaling pins per channel.
// RULE_02: Global status shows debounced input A. The code shows the raw input, with no debouncing.
// RULE_03: Global status shows debounced input B. The code shows the raw input, with no debouncing.
// RULE_04: Local register shows both hook inputs.
// RULE_05: Bidir one direction: 0 input, 1 output.
// RULE_06: Bidir two, three directions same encoding.
// RULE_07: Global register reports bidir input levels.
// RULE_08: Local register shows bidir input levels.
// RULE_09: Bidir output driven only from global data.
// RULE_10: Line outputs driven only from local register.
// RULE_11: Line output bits read back written value.
// RULE_12: Ring trip acts only while enabled.
// RULE_13: Selects choose trip input and output.
// RULE_14: Valid off-hook inverts selected output level.
// RULE_15: Host rewrites output register after trip.
// RULE_16: Input polarity bit gives off-hook level.
// RULE_17: Output polarity bit gives ringing sense.
// RULE_18: Host sets bidir output before selecting it.
// RULE_19: Enabled input changes raise an interrupt.
// RULE_20: Reads clear channel or hook interrupts.
// RULE_21: Forced level holds until rewrite or disable.
module srt_signaling_top
  import srt_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic i_CCLK,
  input wire logic i_CS_N,
  input wire logic i_CI,
  output logic o_CO,
  output logic o_CO_OE_N,
  input wire logic [srt_pkg::SRT_NUM_CH-1:0] i_HOOK_INPUT_A,
  input wire logic [srt_pkg::SRT_NUM_CH-1:0] i_HOOK_INPUT_B,
  input wire logic [srt_pkg::SRT_NUM_CH-1:0] i_BIDIR_PIN_ONE,
  input wire logic [srt_pkg::SRT_NUM_CH-1:0] i_BIDIR_PIN_TWO,
  input wire logic [srt_pkg::SRT_NUM_CH-1:0] i_BIDIR_PIN_THREE,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_ONE,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_TWO,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_THREE,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_ONE_OE_N,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_TWO_OE_N,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_BIDIR_PIN_THREE_OE_N,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_LINE_OUTPUT_ONE,
  output logic [srt_pkg::SRT_NUM_CH-1:0] o_LINE_OUTPUT_TWO,
  output logic o_INT12,
  output logic o_INT34
);
  import srt_pkg::*;

  // -----------------------------------------------------------------
  // Register port
  // -----------------------------------------------------------------
  logic [SRT_BYTE_W-1:0] cmd;
  logic [SRT_BYTE_W-1:0] wr_data;
  logic [SRT_BYTE_W-1:0] rd_data;
  logic wr;
  logic rd;

  srt_mpi_port u_port (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_cclk(i_CCLK),
    .i_cs_n(i_CS_N),
    .i_ci(i_CI),
    .i_rd_data(rd_data),
    .o_cmd(cmd),
    .o_wr(wr),
    .o_wr_data(wr_data),
    .o_rd(rd),
    .o_co(o_CO),
    .o_co_oe_n(o_CO_OE_N)
  );

  // True when the latched command names the given register.
  function automatic logic hits(input logic [SRT_BYTE_W-1:0] c, input logic local_sel,
                                input logic [SRT_CMD_REG_W-1:0] idx);
    hits = (c[SRT_CMD_LOCAL_BIT] == local_sel) && (c[SRT_CMD_REG_LSB +: SRT_CMD_REG_W] == idx);
  endfunction

  wire [SRT_CMD_CH_W-1:0] cmd_ch = cmd[SRT_CMD_CH_LSB +: SRT_CMD_CH_W];
  wire wr_trip_ctl = wr && hits(cmd, 1'b0, SRT_REG_RING_TRIP_CONTROL);
  wire wr_int_clear = wr && hits(cmd, 1'b0, SRT_REG_INT_CLEAR);
  wire wr_sig = wr && hits(cmd, 1'b1, SRT_REG_CHANNEL_SIGNALING);
  wire wr_mask = wr && hits(cmd, 1'b1, SRT_REG_CHANNEL_INT_MASK);
  wire rd_sig = rd && hits(cmd, 1'b1, SRT_REG_CHANNEL_SIGNALING);
  wire rd_deb = rd && hits(cmd, 1'b0, SRT_REG_DEBOUNCED_INPUTS);

  // -----------------------------------------------------------------
  // Registers and per-channel state
  // -----------------------------------------------------------------
  logic [SRT_BYTE_W-1:0] rt_ctrl_reg;
  logic [SRT_NUM_CH-1:0] dir_reg [SRT_NUM_BIDIR];
  logic [SRT_NUM_CH-1:0] bdata_reg [SRT_NUM_BIDIR];
  logic [SRT_NUM_CH-1:0] out1_reg;
  logic [SRT_NUM_CH-1:0] out2_reg;
  logic [SRT_NUM_CH-1:0] trip_reg;
  logic [SRT_NUM_SRC-1:0] mask_reg [SRT_NUM_CH];
  logic [SRT_NUM_SRC-1:0] pend_reg [SRT_NUM_CH];
  logic [SRT_NUM_SRC-1:0] prev_reg [SRT_NUM_CH];
  logic [SRT_NUM_CH-1:0] bidir_in [SRT_NUM_BIDIR];
  logic [SRT_NUM_CH-1:0] bidir_rb [SRT_NUM_BIDIR];
  logic [SRT_NUM_CH-1:0] wr_bidir;
  logic [SRT_NUM_CH-1:0] rd_bidir;
  logic [SRT_NUM_SRC-1:0] src [SRT_NUM_CH];
  logic [SRT_NUM_SRC-1:0] change [SRT_NUM_CH];
  logic [SRT_NUM_SRC-1:0] clr [SRT_NUM_CH];
  logic [SRT_NUM_CH-1:0] irq;
  logic [SRT_NUM_CH-1:0] arrive;
  logic [SRT_NUM_CH-1:0] ringing;
  logic [SRT_NUM_CH-1:0] trip_set;
  logic [SRT_NUM_CH-1:0] trip_clr;
  logic [SRT_BYTE_W-1:0] sig_byte [SRT_NUM_CH];

  wire rt_en = rt_ctrl_reg[SRT_RT_ENABLE_BIT];
  wire rt_insel = rt_ctrl_reg[SRT_RT_INSEL_BIT];
  wire [SRT_RT_OSEL_W-1:0] rt_osel = rt_ctrl_reg[SRT_RT_OSEL_LSB +: SRT_RT_OSEL_W];
  wire rt_ipol = rt_ctrl_reg[SRT_RT_IPOL_BIT];
  wire rt_opol = rt_ctrl_reg[SRT_RT_OPOL_BIT];

  assign bidir_in[0] = i_BIDIR_PIN_ONE;
  assign bidir_in[1] = i_BIDIR_PIN_TWO;
  assign bidir_in[2] = i_BIDIR_PIN_THREE;

  // -----------------------------------------------------------------
  // Bidirectional pin registers, one per pin number
  // -----------------------------------------------------------------
  for (genvar k = 0; k < SRT_NUM_BIDIR; k++) begin : g_bidir
    localparam logic [3:0] IDX = SRT_REG_BIDIR_PIN1 + 4'(k);
    assign wr_bidir[k] = wr && hits(cmd, 1'b0, IDX);
    assign rd_bidir[k] = rd && hits(cmd, 1'b0, IDX);
    // Input channels read the pin, output channels read the written data.
    assign bidir_rb[k] = (dir_reg[k] & bdata_reg[k]) | (~dir_reg[k] & bidir_in[k]); // RULE_07

    // Direction and output data; 1 drives, 0 listens.
    always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
        dir_reg[k] <= '0;
        bdata_reg[k] <= '0;
      end else if (wr_bidir[k]) begin
        dir_reg[k] <= wr_data[SRT_BIDIR_DIR_LSB +: SRT_NUM_CH]; // RULE_05 RULE_06
        bdata_reg[k] <= wr_data[SRT_BIDIR_DATA_LSB +: SRT_NUM_CH]; // RULE_09
      end
    end
  end
  assign wr_bidir[SRT_NUM_CH-1] = 1'b0;
  assign rd_bidir[SRT_NUM_CH-1] = 1'b0;

  // -----------------------------------------------------------------
  // Per-channel interrupt sources and ring trip
  // -----------------------------------------------------------------
  for (genvar ch = 0; ch < SRT_NUM_CH; ch++) begin : g_ch
    wire me = (cmd_ch == 2'(ch));
    wire [SRT_NUM_BIDIR-1:0] bin = {bidir_in[2][ch], bidir_in[1][ch], bidir_in[0][ch]};
    wire [SRT_NUM_BIDIR-1:0] bdir = {dir_reg[2][ch], dir_reg[1][ch], dir_reg[0][ch]};
    wire [SRT_NUM_BIDIR-1:0] bdat = {bdata_reg[2][ch], bdata_reg[1][ch], bdata_reg[0][ch]};
    wire [SRT_NUM_SRC-1:0] valid = {~bdir, 2'b11};
    wire [SRT_NUM_SRC-1:0] clr_hook = {3'b000, rd_deb, rd_deb};
    wire [SRT_NUM_SRC-1:0] clr_all = {SRT_NUM_SRC{wr_int_clear | (rd_sig & me)}};
    wire sel_in = rt_insel ? src[ch][SRT_SRC_B] : src[ch][SRT_SRC_A];
    wire sel_prev = rt_insel ? prev_reg[ch][SRT_SRC_B] : prev_reg[ch][SRT_SRC_A];
    wire [SRT_NUM_SRC-1:0] ctl_all = {bdat, out2_reg[ch], out1_reg[ch]};
    wire [SRT_NUM_SRC-1:0] rewrite = {wr_bidir[2:0], wr_sig & me, wr_sig & me};
    wire [SRT_NUM_SRC-1:0] osel_hot = SRT_NUM_SRC'(1) << rt_osel;

    assign src[ch] = {bin, i_HOOK_INPUT_B[ch], i_HOOK_INPUT_A[ch]};
    // Bidir pins count as sources only while they are inputs.
    assign change[ch] = (src[ch] ^ prev_reg[ch]) & valid; // RULE_19
    assign clr[ch] = clr_all | clr_hook | {rd_bidir[2:0], 2'b00}; // RULE_20
    assign irq[ch] = |(pend_reg[ch] & mask_reg[ch]);
    // Off-hook arrives when the chosen input reaches the valid level.
    assign arrive[ch] = (sel_in == rt_ipol) && (sel_prev != rt_ipol); // RULE_13 RULE_16
    // Only an output that sits at its ringing level is tripped.
    assign ringing[ch] = ((ctl_all & osel_hot) != '0) == rt_opol; // RULE_17
    assign trip_set[ch] = rt_en && arrive[ch] && ringing[ch] && (osel_hot != '0); // RULE_12 RULE_14
    assign trip_clr[ch] = !rt_en || ((rewrite & osel_hot) != '0); // RULE_15 RULE_21
    assign sig_byte[ch] = {1'b0, out2_reg[ch], out1_reg[ch], bin, // RULE_11 RULE_08
                           i_HOOK_INPUT_B[ch], i_HOOK_INPUT_A[ch]}; // RULE_04

    // Pending flags; a new change wins over a clear in the same cycle.
    always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
        pend_reg[ch] <= '0;
        prev_reg[ch] <= '0;
        mask_reg[ch] <= '0;
      end else begin
        pend_reg[ch] <= (change[ch] & mask_reg[ch]) | (pend_reg[ch] & ~clr[ch]); // RULE_19
        prev_reg[ch] <= src[ch];
        if (wr_mask && me) begin
          mask_reg[ch] <= wr_data[SRT_NUM_SRC-1:0];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Global control, line outputs and trip state
  // -----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rt_ctrl_reg <= SRT_RESET_BYTE;
      trip_reg <= '0;
    end else begin
      if (wr_trip_ctl) begin
        rt_ctrl_reg <= wr_data;
      end
      trip_reg <= trip_set | (trip_reg & ~trip_clr); // RULE_21
    end
  end

  // Line outputs are written per channel through the local register only.
  for (genvar ch = 0; ch < SRT_NUM_CH; ch++) begin : g_out
    always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
        out1_reg[ch] <= 1'b0;
        out2_reg[ch] <= 1'b0;
      end else if (wr_sig && (cmd_ch == 2'(ch))) begin
        out1_reg[ch] <= wr_data[SRT_SIG_OUT1_BIT]; // RULE_10
        out2_reg[ch] <= wr_data[SRT_SIG_OUT2_BIT]; // RULE_10
      end
    end
  end

  // -----------------------------------------------------------------
  // Pin drivers; the trip inverts only the selected output
  // -----------------------------------------------------------------
  wire [SRT_NUM_CH-1:0] inv1 = trip_reg & {SRT_NUM_CH{rt_osel == SRT_OSEL_OUT1}};
  wire [SRT_NUM_CH-1:0] inv2 = trip_reg & {SRT_NUM_CH{rt_osel == SRT_OSEL_OUT2}};
  wire [SRT_NUM_CH-1:0] invb1 = trip_reg & {SRT_NUM_CH{rt_osel == SRT_OSEL_BIDIR1}};
  wire [SRT_NUM_CH-1:0] invb2 = trip_reg & {SRT_NUM_CH{rt_osel == SRT_OSEL_BIDIR1 + 3'h1}};
  wire [SRT_NUM_CH-1:0] invb3 = trip_reg & {SRT_NUM_CH{rt_osel == SRT_OSEL_BIDIR1 + 3'h2}};
  wire irq12 = irq[0] | irq[1];
  wire irq34 = irq[2] | irq[3];

  // All pin and interrupt outputs leave from flip-flops.
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      o_LINE_OUTPUT_ONE <= '0;
      o_LINE_OUTPUT_TWO <= '0;
      o_BIDIR_PIN_ONE <= '0;
      o_BIDIR_PIN_TWO <= '0;
      o_BIDIR_PIN_THREE <= '0;
      o_BIDIR_PIN_ONE_OE_N <= '1;
      o_BIDIR_PIN_TWO_OE_N <= '1;
      o_BIDIR_PIN_THREE_OE_N <= '1;
      o_INT12 <= 1'b0;
      o_INT34 <= 1'b0;
    end else begin
      o_LINE_OUTPUT_ONE <= out1_reg ^ inv1; // RULE_01 RULE_14
      o_LINE_OUTPUT_TWO <= out2_reg ^ inv2; // RULE_14
      o_BIDIR_PIN_ONE <= bdata_reg[0] ^ invb1; // RULE_09 RULE_18
      o_BIDIR_PIN_TWO <= bdata_reg[1] ^ invb2; // RULE_09
      o_BIDIR_PIN_THREE <= bdata_reg[2] ^ invb3; // RULE_09
      o_BIDIR_PIN_ONE_OE_N <= ~dir_reg[0]; // RULE_05
      o_BIDIR_PIN_TWO_OE_N <= ~dir_reg[1]; // RULE_06
      o_BIDIR_PIN_THREE_OE_N <= ~dir_reg[2]; // RULE_06
      o_INT12 <= irq12;
      o_INT34 <= irq34;
    end
  end

  // -----------------------------------------------------------------
  // Read data selection
  // -----------------------------------------------------------------
  wire [SRT_BYTE_W-1:0] deb_byte = {i_HOOK_INPUT_B, i_HOOK_INPUT_A}; // RULE_02 RULE_03
  wire [SRT_BYTE_W-1:0] mask_byte = {3'b000, mask_reg[cmd_ch]};
  wire [SRT_BYTE_W-1:0] bidir_byte [SRT_NUM_BIDIR];
  assign bidir_byte[0] = {dir_reg[0], bidir_rb[0]};
  assign bidir_byte[1] = {dir_reg[1], bidir_rb[1]};
  assign bidir_byte[2] = {dir_reg[2], bidir_rb[2]};
  assign rd_data =
    hits(cmd, 1'b1, SRT_REG_CHANNEL_SIGNALING) ? sig_byte[cmd_ch] :
    hits(cmd, 1'b1, SRT_REG_CHANNEL_INT_MASK) ? mask_byte :
    hits(cmd, 1'b0, SRT_REG_RING_TRIP_CONTROL) ? rt_ctrl_reg :
    hits(cmd, 1'b0, SRT_REG_DEBOUNCED_INPUTS) ? deb_byte :
    hits(cmd, 1'b0, SRT_REG_BIDIR_PIN1) ? bidir_byte[0] :
    hits(cmd, 1'b0, SRT_REG_BIDIR_PIN1 + 4'h1) ? bidir_byte[1] :
    hits(cmd, 1'b0, SRT_REG_BIDIR_PIN1 + 4'h2) ? bidir_byte[2] :
    SRT_RESET_BYTE;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  sequence s_hook_change;
    change[0][SRT_SRC_A] && mask_reg[0][SRT_SRC_A];
  endsequence
  sequence s_trip_out1;
    trip_reg[0] && (rt_osel == SRT_OSEL_OUT1);
  endsequence

  a_disabled_no_trip: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_12
    !rt_en |=> (trip_reg == '0)) else $error("trip held while disabled");
  a_trip_inverts_out: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_14
    s_trip_out1 |=> (o_LINE_OUTPUT_ONE[0] != $past(out1_reg[0])))
    else $error("tripped output not inverted");
  a_trip_holds_level: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_21
    (trip_reg[0] && !trip_clr[0]) |=> trip_reg[0]) else $error("trip dropped early");
  a_trip_on_offhook: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_16
    (rt_en && arrive[0] && ringing[0] && rt_osel == SRT_OSEL_OUT2) |-> ##2
    (o_LINE_OUTPUT_TWO[0] == ~rt_opol)) else $error("off-hook did not trip");
  a_bidir_dir_enable: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_05
    $rose(dir_reg[0][0]) |=> !o_BIDIR_PIN_ONE_OE_N[0]) else $error("pin not driven");
  a_out_follows_reg: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_10
    (!trip_reg[1]) |=> (o_LINE_OUTPUT_ONE[1] == $past(out1_reg[1])))
    else $error("line output not from register");
  a_hook_int_raise: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_19
    s_hook_change |-> ##2 o_INT12) else $error("interrupt not raised");
  a_local_read_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_20
    (rd_sig && cmd_ch == 2'h2 && change[2] == '0) |=> (pend_reg[2] == '0))
    else $error("local read did not clear");
  a_global_read_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_20
    (rd_deb && change[0][SRT_SRC_A] == 1'b0) |=> !pend_reg[0][SRT_SRC_A])
    else $error("global read did not clear");

endmodule

// file: src/srt_pkg.sv
package srt_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int SRT_NUM_CH = 4;
  localparam int SRT_BYTE_W = 8;
  localparam int SRT_NUM_SRC = 5;
  localparam int SRT_NUM_BIDIR = 3;
  localparam int SRT_CNT_W = 3;
  localparam logic [2:0] SRT_LAST_BIT = 3'h7;
  localparam logic [7:0] SRT_RESET_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Command byte layout on the serial control port
  // ---------------------------------------------------------------
  localparam int SRT_CMD_READ_BIT = 7;
  localparam int SRT_CMD_LOCAL_BIT = 6;
  localparam int SRT_CMD_CH_LSB = 4;
  localparam int SRT_CMD_CH_W = 2;
  localparam int SRT_CMD_REG_LSB = 0;
  localparam int SRT_CMD_REG_W = 4;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] SRT_REG_INT_CLEAR = 4'h2;
  localparam logic [3:0] SRT_REG_RING_TRIP_CONTROL = 4'h8;
  localparam logic [3:0] SRT_REG_DEBOUNCED_INPUTS = 4'h9;
  localparam logic [3:0] SRT_REG_BIDIR_PIN1 = 4'ha;
  localparam logic [3:0] SRT_REG_CHANNEL_INT_MASK = 4'h2;
  localparam logic [3:0] SRT_REG_CHANNEL_SIGNALING = 4'h4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SRT_RT_ENABLE_BIT = 0;
  localparam int SRT_RT_INSEL_BIT = 1;
  localparam int SRT_RT_OSEL_LSB = 2;
  localparam int SRT_RT_OSEL_W = 3;
  localparam int SRT_RT_IPOL_BIT = 5;
  localparam int SRT_RT_OPOL_BIT = 6;
  localparam int SRT_BIDIR_DATA_LSB = 0;
  localparam int SRT_BIDIR_DIR_LSB = 4;
  localparam int SRT_DEB_A_LSB = 0;
  localparam int SRT_DEB_B_LSB = 4;
  localparam int SRT_SIG_OUT1_BIT = 5;
  localparam int SRT_SIG_OUT2_BIT = 6;
  localparam int SRT_SRC_A = 0;
  localparam int SRT_SRC_B = 1;
  localparam int SRT_SRC_BIDIR_LSB = 2;

  // ---------------------------------------------------------------
  // Ring-control output select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SRT_OSEL_OUT1 = 3'h0;
  localparam logic [2:0] SRT_OSEL_OUT2 = 3'h1;
  localparam logic [2:0] SRT_OSEL_BIDIR1 = 3'h2;

  // Serial port states, Gray coded along idle, command, data, done.
  typedef enum logic [1:0] {
    SRT_ST_IDLE = 2'h0,
    SRT_ST_CMD = 2'h1,
    SRT_ST_DATA = 2'h3,
    SRT_ST_DONE = 2'h2
  } srt_state_type;

endpackage

// file: src/srt_mpi_port.sv
`timescale 1ns/1ps
module srt_mpi_port
  import srt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cclk,
  input wire logic i_cs_n,
  input wire logic i_ci,
  input wire logic [srt_pkg::SRT_BYTE_W-1:0] i_rd_data,
  output logic [srt_pkg::SRT_BYTE_W-1:0] o_cmd,
  output logic o_wr,
  output logic [srt_pkg::SRT_BYTE_W-1:0] o_wr_data,
  output logic o_rd,
  output logic o_co,
  output logic o_co_oe_n
);
  import srt_pkg::*;

  // -----------------------------------------------------------------
  // Edge detection and next-value terms
  // -----------------------------------------------------------------
  srt_state_type state_reg;
  srt_state_type state_next;
  logic cclk_prev_reg;
  logic [SRT_CNT_W-1:0] cnt_reg;
  logic [SRT_BYTE_W-1:0] in_reg;
  logic [SRT_BYTE_W-1:0] out_reg;
  logic [SRT_BYTE_W-1:0] cmd_reg;
  logic [SRT_BYTE_W-1:0] wr_data_reg;
  logic wr_reg;
  logic rd_reg;
  logic co_reg;
  logic oe_n_reg;
  logic reading_reg;

  // The control clock is sampled as plain data; edges are found here.
  wire rise = i_cclk & ~cclk_prev_reg;
  wire fall = ~i_cclk & cclk_prev_reg;
  wire byte_end = rise && (cnt_reg == SRT_LAST_BIT);
  wire [SRT_BYTE_W-1:0] in_byte = {in_reg[SRT_BYTE_W-2:0], i_ci};
  wire cmd_end = (state_reg == SRT_ST_CMD) && byte_end;
  wire data_end = (state_reg == SRT_ST_DATA) && !reading_reg && byte_end;

  // Next state; chip select high always ends the transfer.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRT_ST_IDLE: state_next = i_cs_n ? SRT_ST_IDLE : SRT_ST_CMD;
      SRT_ST_CMD: state_next = cmd_end ? SRT_ST_DATA : SRT_ST_CMD;
      SRT_ST_DATA: state_next = data_end ? SRT_ST_DONE : SRT_ST_DATA;
      SRT_ST_DONE: state_next = SRT_ST_DONE;
      default: state_next = SRT_ST_IDLE;
    endcase
    if (i_cs_n) begin
      state_next = SRT_ST_IDLE;
    end
  end

  // State, edge memory and bit counter.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= SRT_ST_IDLE;
      cclk_prev_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cclk_prev_reg <= i_cclk;
      if (state_reg == SRT_ST_IDLE) begin
        cnt_reg <= '0;
      end else if (rise) begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

  // Input shifter, command latch, write and read strobes.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_reg <= SRT_RESET_BYTE;
      cmd_reg <= SRT_RESET_BYTE;
      wr_data_reg <= SRT_RESET_BYTE;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      reading_reg <= 1'b0;
    end else begin
      if (rise) begin
        in_reg <= in_byte;
      end
      if (cmd_end) begin
        cmd_reg <= in_byte;
        reading_reg <= in_byte[SRT_CMD_READ_BIT];
      end
      if (data_end) begin
        wr_data_reg <= in_byte;
      end
      wr_reg <= data_end;
      rd_reg <= cmd_end && in_byte[SRT_CMD_READ_BIT];
    end
  end

  // Output shifter; data leaves on falling control clock edges, MSB first.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_reg <= SRT_RESET_BYTE;
      co_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (i_cs_n) begin
      oe_n_reg <= 1'b1;
    end else if (rd_reg) begin
      out_reg <= i_rd_data;
    end else if (fall && reading_reg && (state_reg == SRT_ST_DATA)) begin
      co_reg <= out_reg[SRT_BYTE_W-1];
      out_reg <= {out_reg[SRT_BYTE_W-2:0], 1'b0};
      oe_n_reg <= 1'b0;
    end
  end

  assign o_cmd = cmd_reg;
  assign o_wr = wr_reg;
  assign o_wr_data = wr_data_reg;
  assign o_rd = rd_reg;
  assign o_co = co_reg;
  assign o_co_oe_n = oe_n_reg;

endmodule

// file: tb/srt_slic_model.sv
`timescale 1ns/1ps
module srt_slic_model (
  input wire logic [11:0] i_dev_level,
  input wire logic [11:0] i_dev_oe_n,
  input wire logic [11:0] i_slic_level,
  output logic [11:0] o_pin_level
);
  // A pin follows the codec where it drives, else the line circuit's own level.
  assign o_pin_level = (i_dev_level & ~i_dev_oe_n) | (i_slic_level & i_dev_oe_n);
endmodule

// file: tb/srt_signaling_top_tb_top.sv
`timescale 1ns/1ps
module srt_signaling_top_tb_top;
  import srt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cclk = 1'b0;
  logic cs_n = 1'b1;
  logic ci = 1'b0;
  logic co, co_oe_n, int12, int34;
  logic [3:0] hook_a = 4'h5;
  logic [3:0] hook_b = 4'ha;
  logic [11:0] slic_lvl = 12'h444;
  logic [11:0] pin_lvl, dev_lvl, dev_oe_n;
  logic [3:0] out1, out2;
  logic [7:0] rd = 8'h00;
  logic oe_on = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  // ---------------------------------------------------------------
  // Clock, design and line circuit
  // ---------------------------------------------------------------
  always #2.5 clk = ~clk;
  srt_signaling_top srt_signaling_top_i (
    .I_CLK(clk), .I_RST_N(rst_n), .i_CCLK(cclk), .i_CS_N(cs_n), .i_CI(ci),
    .o_CO(co), .o_CO_OE_N(co_oe_n), .i_HOOK_INPUT_A(hook_a), .i_HOOK_INPUT_B(hook_b),
    .i_BIDIR_PIN_ONE(pin_lvl[3:0]), .i_BIDIR_PIN_TWO(pin_lvl[7:4]),
    .i_BIDIR_PIN_THREE(pin_lvl[11:8]), .o_BIDIR_PIN_ONE(dev_lvl[3:0]),
    .o_BIDIR_PIN_TWO(dev_lvl[7:4]), .o_BIDIR_PIN_THREE(dev_lvl[11:8]),
    .o_BIDIR_PIN_ONE_OE_N(dev_oe_n[3:0]), .o_BIDIR_PIN_TWO_OE_N(dev_oe_n[7:4]),
    .o_BIDIR_PIN_THREE_OE_N(dev_oe_n[11:8]), .o_LINE_OUTPUT_ONE(out1),
    .o_LINE_OUTPUT_TWO(out2), .o_INT12(int12), .o_INT34(int34));
  srt_slic_model srt_slic_model_i (.i_dev_level(dev_lvl), .i_dev_oe_n(dev_oe_n),
    .i_slic_level(slic_lvl), .o_pin_level(pin_lvl));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Steps n clock edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One command byte and one data byte; read bits are taken before each rise.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {cmd, wd};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      cclk = 1'b0;
      ci = sh[i];
      tick(4);
      if (i < 8) rd[i] = co;
      if (i == 0) oe_on = ~co_oe_n;
      cclk = 1'b1;
      tick(4);
    end
    cclk = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hung transfer ends the run as a failure.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(2);
    chk("oe_n", dev_oe_n[7:0], 8'hff);
    xfer(8'h89, 8'h00);
    chk("debounced", rd, 8'ha5);
    chk("co drive", 8'(oe_on), 8'h01);
    chk("co release", 8'(co_oe_n), 8'h01);
    xfer(8'he4, 8'h00);
    chk("sig ch3", rd, 8'h1d);
    for (int k = 0; k < 3; k++) begin
      xfer(8'h0a + 8'(k), 8'h31);
      chk("bidir oe_n", 8'(dev_oe_n[4*k+:4]), 8'h0c);
      chk("bidir level", 8'(dev_lvl[4*k+:4]), 8'h01);
      xfer(8'h8a + 8'(k), 8'h00);
      chk("bidir read", rd, 8'h35);
    end
    xfer(8'h44, 8'h1c);
    chk("bidir local", dev_lvl[7:0], 8'h11);
    xfer(8'h54, 8'h60);
    chk("line out", {out2, out1}, 8'h22);
    xfer(8'hd4, 8'h00);
    chk("sig ch2", rd, 8'h62);
    xfer(8'h42, 8'h01);
    hook_a[0] = 1'b0;
    tick(4);
    chk("int set", 8'(int12), 8'h01);
    xfer(8'h89, 8'h00);
    chk("int read clr", 8'(int12), 8'h00);
    hook_a[0] = 1'b1;
    tick(4);
    xfer(8'h02, 8'h00);
    chk("int write clr", 8'(int12), 8'h00);
    xfer(8'h62, 8'h02);
    hook_b[2] = 1'b1;
    tick(4);
    chk("int34 set", 8'(int34), 8'h01);
    xfer(8'he4, 8'h00);
    chk("sig ch3 b", rd, 8'h1f);
    chk("int34 clr", 8'(int34), 8'h00);
    xfer(8'h44, 8'h20);
    xfer(8'h08, 8'h41);
    hook_a[0] = 1'b0;
    tick(4);
    chk("trip out1", 8'(out1), 8'h02);
    xfer(8'h08, 8'h40);
    chk("trip off", 8'(out1), 8'h03);
    hook_a[0] = 1'b1;
    tick(4);
    hook_a[0] = 1'b0;
    tick(4);
    chk("no trip", 8'(out1), 8'h03);
    xfer(8'h08, 8'h6b);
    hook_b[0] = 1'b1;
    tick(4);
    chk("trip bidir", 8'(dev_lvl[3:0]), 8'h00);
    xfer(8'h0a, 8'h30);
    chk("rewrite match", 8'(dev_lvl[3:0]), 8'h00);
    xfer(8'h0a, 8'h31);
    chk("trip ended", 8'(dev_lvl[3:0]), 8'h01);
    hook_a[0] = 1'b1;
    tick(4);
    xfer(8'h08, 8'h05);
    hook_a[0] = 1'b0;
    tick(4);
    chk("trip out2", 8'(out2), 8'h03);
    report_and_stop();
  end
endmodule
